/* File: logic/store_qual_pkg.sv */
// Purpose: shared constants for trace storage qualification and execute start
// Assumes: one clock, synchronous pin inputs
// Notes:   term numbers are zero based inside the logic
`default_nettype none
package store_qual_pkg;
  localparam int unsigned COMPLEX_TERMS = 8;
  localparam int unsigned TERM_W        = 3;
  localparam int unsigned EXPR_W        = 4;
  localparam logic [EXPR_W-1:0] EXPR_ALL = 4'hF;
  localparam logic        CFG_EASY      = 1'b0;
  localparam logic        CFG_COMPLEX   = 1'b1;
  typedef enum logic [1:0] {
    XS_IDLE,
    XS_DRIVE,
    XS_WAIT_RELEASE
  } exec_state_e;
endpackage
`default_nettype wire

/* File: logic/qual_store_mem.sv */
// Purpose: per-term storage expression memory, registered read
// Assumes: single write port, single read port
// Notes:   clear returns every entry to the store-all code
`timescale 1ns/10ps
`default_nettype none
module qual_store_mem
  import store_qual_pkg::*;
#(
  parameter int unsigned DEPTH = COMPLEX_TERMS,
  parameter int unsigned AW    = TERM_W,
  parameter int unsigned DW    = EXPR_W
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          clear,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);
  logic [DW-1:0] mem_reg  [DEPTH];
  logic [DW-1:0] mem_next [DEPTH];
  logic [DW-1:0] rd_next;

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      if (clear) begin
        mem_next[i] = DW'(EXPR_ALL);
      end else if (wr_en && (int'(wr_addr) == i)) begin
        mem_next[i] = wr_data;
      end else begin
        mem_next[i] = mem_reg[i];
      end
    end
    rd_next = clear ? DW'(EXPR_ALL) : mem_reg[rd_addr];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= DW'(EXPR_ALL);
      end
      rd_data <= DW'(EXPR_ALL);
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= mem_next[i];
      end
      rd_data <= rd_next;
    end
  end
endmodule // qual_store_mem
`default_nettype wire

/* File: logic/trace_store_qualify_exec_start.sv */
// Purpose: storage qualification of captured states and execute-triggered start
// Assumes: pins synchronous to clk; expression hits decoded outside into EXPR_W lines
// Notes:   an expression is a mask over match lines; all ones means store any state
`timescale 1ns/10ps
`default_nettype none
// Function
// - power-up or initialize makes every captured state stored
// - switching easy/complex configuration resets storage qualifier to store all
// - easy configuration uses one global expression regardless of sequencer term
// - complex term expression stores matches only while sequencer sits at that term
// - complex global expression stores matches at any sequencer level
// - setting a trigger condition leaves storage qualifiers untouched
// - execute request starts measurement when enabled, ignored when disabled
// - execute-start option disabled after power-up or initialize
// - on execute request, drive shared trigger line at once
// - if no internal trigger line driven, start right after asserting shared line
// - then release shared line and wait until every participant released it
// - shared line reads false after last release; internal-line drivers start then
// - per-term qualifiers only in complex configuration, eight terms there
module trace_store_qualify_exec_start
  import store_qual_pkg::*;
#(
  parameter int unsigned TERMS = COMPLEX_TERMS,
  parameter int unsigned TW    = TERM_W,
  parameter int unsigned EW    = EXPR_W
) (
  input  wire logic          clk,
  input  wire logic          rstn,
  input  wire logic          analyzer_init,
  input  wire logic          cfg_complex,
  input  wire logic          trigger_condition_set,
  input  wire logic          global_expr_wr,
  input  wire logic          term_expr_wr,
  input  wire logic [TW-1:0] expr_term,
  input  wire logic [EW-1:0] expr_value,
  input  wire logic [TW-1:0] seq_term,
  input  wire logic          state_valid,
  input  wire logic [EW-1:0] state_match,
  input  wire logic          exec_enable_wr,
  input  wire logic          exec_enable_val,
  input  wire logic          exec_request,
  input  wire logic          internal_trigger_line_a,
  input  wire logic          internal_trigger_line_b,
  input  wire logic          shared_trig_in,
  output logic               shared_trig_out,
  output logic               shared_trig_oe,
  output logic               store_state,
  output logic               meas_start,
  output logic               exec_enabled,
  output logic               exec_busy
);
  logic rst_sync1_reg;
  logic rst_sync2_reg;
  wire  logic rst_n = rst_sync2_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync1_reg <= 1'b0;
      rst_sync2_reg <= 1'b0;
    end else begin
      rst_sync1_reg <= 1'b1;
      rst_sync2_reg <= rst_sync1_reg;
    end
  end

  // a mask of all ones matches every state; otherwise any selected match line hits
  function automatic logic expr_hit(input logic [EW-1:0] mask, input logic [EW-1:0] hit);
    expr_hit = (mask == EW'(EXPR_ALL)) || ((mask & hit) != '0);
  endfunction

  // storage qualifier state
  logic          cfg_reg,      cfg_next;
  logic [EW-1:0] glob_reg,     glob_next;
  logic          glob_only_reg, glob_only_next;
  logic [TERMS-1:0] term_set_reg, term_set_next;
  logic          qual_clear;
  logic          term_wr;
  logic [EW-1:0] term_expr;
  logic          valid_d_reg;
  logic [EW-1:0] match_d_reg;
  logic [TW-1:0] term_d_reg;
  logic          store_next;

  assign qual_clear = analyzer_init || (cfg_complex != cfg_reg);
  assign term_wr    = term_expr_wr && cfg_complex && !qual_clear;

  qual_store_mem #(
    .DEPTH (TERMS),
    .AW    (TW),
    .DW    (EW)
  ) u_term_mem (
    .clk     (clk),
    .rst_n   (rst_n),
    .clear   (qual_clear),
    .wr_en   (term_wr),
    .wr_addr (expr_term),
    .wr_data (expr_value),
    .rd_addr (seq_term),
    .rd_data (term_expr)
  );

  // trigger_condition_set deliberately touches none of this state
  always_comb begin
    cfg_next       = cfg_complex;
    glob_next      = glob_reg;
    glob_only_next = glob_only_reg;
    term_set_next  = term_set_reg;
    if (qual_clear) begin
      glob_next      = EW'(EXPR_ALL);
      glob_only_next = 1'b1;
      term_set_next  = '0;
    end else begin
      if (global_expr_wr) begin
        glob_next      = expr_value;
        glob_only_next = 1'b0;
      end
      if (term_wr) begin
        term_set_next[expr_term] = 1'b1;
      end
    end
    // memory read lags one cycle, so the state is delayed to line up with it
    store_next = 1'b0;
    if (valid_d_reg) begin
      if (cfg_reg == CFG_EASY || !term_set_reg[term_d_reg]) begin
        store_next = expr_hit(glob_reg, match_d_reg);
      end else begin
        // a term expression narrows storage at its level; a global one written since the last clear still applies
        store_next = expr_hit(term_expr, match_d_reg) ||
                     (!glob_only_reg && expr_hit(glob_reg, match_d_reg));
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg       <= CFG_EASY;
      glob_reg      <= EW'(EXPR_ALL);
      glob_only_reg <= 1'b1;
      term_set_reg  <= '0;
      valid_d_reg   <= 1'b0;
      match_d_reg   <= '0;
      term_d_reg    <= '0;
      store_state   <= 1'b0;
    end else begin
      cfg_reg       <= cfg_next;
      glob_reg      <= glob_next;
      glob_only_reg <= glob_only_next;
      term_set_reg  <= term_set_next;
      valid_d_reg   <= state_valid;
      match_d_reg   <= state_match;
      term_d_reg    <= seq_term;
      store_state   <= store_next;
    end
  end

  // execute-start sequencing
  exec_state_e xs_reg, xs_next;
  logic        en_next;
  logic        trig_out_next;
  logic        start_next;
  logic        busy_next;
  logic        int_drive;

  assign int_drive = internal_trigger_line_a || internal_trigger_line_b;

  always_comb begin
    xs_next       = xs_reg;
    en_next       = exec_enabled;
    trig_out_next = 1'b0;
    start_next    = 1'b0;
    if (analyzer_init) begin
      en_next = 1'b0;
    end else if (exec_enable_wr) begin
      en_next = exec_enable_val;
    end
    unique case (xs_reg)
      XS_IDLE: begin
        if (exec_request && exec_enabled && !analyzer_init) begin
          xs_next       = XS_DRIVE;
          trig_out_next = 1'b1;
        end
      end
      XS_DRIVE: begin
        // line is driven this cycle; start here if no internal line is ours
        start_next = !int_drive;
        xs_next    = XS_WAIT_RELEASE;
      end
      XS_WAIT_RELEASE: begin
        // wired-OR: line stays high while any other participant holds it
        if (!shared_trig_in) begin
          start_next = int_drive;
          xs_next    = XS_IDLE;
        end
      end
    endcase
    if (analyzer_init) begin
      xs_next       = XS_IDLE;
      trig_out_next = 1'b0;
      start_next    = 1'b0;
    end
    busy_next = (xs_next != XS_IDLE);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      xs_reg          <= XS_IDLE;
      exec_enabled    <= 1'b0;
      shared_trig_out <= 1'b0;
      shared_trig_oe  <= 1'b0;
      meas_start      <= 1'b0;
      exec_busy       <= 1'b0;
    end else begin
      xs_reg          <= xs_next;
      exec_enabled    <= en_next;
      shared_trig_out <= trig_out_next;
      shared_trig_oe  <= trig_out_next;
      meas_start      <= start_next;
      exec_busy       <= busy_next;
    end
  end
endmodule // trace_store_qualify_exec_start
`default_nettype wire

/* File: test/trig_peer_model.sv */
// Purpose: other instrument on the shared trigger line
// Assumes: sees the line one cycle late
// Notes: hold_len 0 means it never drives
`timescale 1ns/10ps
`default_nettype none
module trig_peer_model (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       shared_trig_oe,
  input  wire logic       shared_trig_out,
  input  wire logic [3:0] hold_len,
  output logic            peer_drive
);
  logic [3:0] cnt_reg;
  // keeps the line up after ours, then lets it fall to the pull-down
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) cnt_reg <= 4'h0;
    else if (shared_trig_oe && shared_trig_out) cnt_reg <= hold_len;
    else if (cnt_reg != 4'h0) cnt_reg <= cnt_reg - 4'h1;
  end
  assign peer_drive = (cnt_reg != 4'h0);
endmodule // trig_peer_model
`default_nettype wire

/* File: test/trace_store_qualify_exec_start_chk.sv */
// Purpose: port assertions for storage qualify and execute start
// Assumes: pins sampled on rising clk
// Notes: bound to the top module
`timescale 1ns/10ps
`default_nettype none
module trace_store_qualify_exec_start_chk (
  input wire logic clk,
  input wire logic rstn,
  input wire logic analyzer_init,
  input wire logic cfg_complex,
  input wire logic global_expr_wr,
  input wire logic term_expr_wr,
  input wire logic state_valid,
  input wire logic exec_request,
  input wire logic internal_trigger_line_a,
  input wire logic internal_trigger_line_b,
  input wire logic shared_trig_in,
  input wire logic shared_trig_oe,
  input wire logic shared_trig_out,
  input wire logic store_state,
  input wire logic meas_start,
  input wire logic exec_enabled,
  input wire logic exec_busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_store_delay: assert property (store_state |-> $past(state_valid, 2))
    else $error("stray store");
  // a fresh expression written right after the clear may legally narrow storage
  chk_init_all: assert property (analyzer_init ##1 !(global_expr_wr || term_expr_wr)
    ##1 (state_valid && !(global_expr_wr || term_expr_wr)) |-> ##2 store_state)
    else $error("init no store");
  chk_cfg_all: assert property ($changed(cfg_complex) ##1 !(global_expr_wr || term_expr_wr)
    ##1 (state_valid && !(global_expr_wr || term_expr_wr)) |-> ##2 store_state)
    else $error("cfg no store");
  chk_init_exec: assert property (analyzer_init |=> !exec_enabled)
    else $error("exec kept");
  chk_exec_off: assert property (exec_request && !exec_enabled |=> !shared_trig_oe)
    else $error("exec not ignored");
  chk_exec_drive: assert property (exec_request && exec_enabled && !exec_busy
    && !analyzer_init |=> shared_trig_oe && shared_trig_out && exec_busy)
    else $error("no drive");
  chk_drive_once: assert property (shared_trig_oe |=> !shared_trig_oe)
    else $error("line held");
  chk_start_direct: assert property (shared_trig_oe && !internal_trigger_line_a
    && !internal_trigger_line_b |=> meas_start) else $error("no direct start");
  chk_start_wait: assert property (exec_busy && !shared_trig_oe && !shared_trig_in
    && !analyzer_init && (internal_trigger_line_a || internal_trigger_line_b)
    |=> meas_start && !exec_busy)
    else $error("no late start");
  cover property (meas_start && internal_trigger_line_a);
  cover property (exec_busy && shared_trig_in && !shared_trig_oe);
  cover property ($changed(cfg_complex));
endmodule // trace_store_qualify_exec_start_chk
bind trace_store_qualify_exec_start trace_store_qualify_exec_start_chk i_chk (
  .clk (clk), .rstn (rstn), .analyzer_init (analyzer_init), .cfg_complex (cfg_complex),
  .global_expr_wr (global_expr_wr), .term_expr_wr (term_expr_wr),
  .state_valid (state_valid), .exec_request (exec_request),
  .internal_trigger_line_a (internal_trigger_line_a),
  .internal_trigger_line_b (internal_trigger_line_b), .shared_trig_in (shared_trig_in),
  .shared_trig_oe (shared_trig_oe), .shared_trig_out (shared_trig_out),
  .store_state (store_state), .meas_start (meas_start), .exec_enabled (exec_enabled),
  .exec_busy (exec_busy)
);
`default_nettype wire

/* File: test/tb_trace_store_qualify_exec_start.sv */
// Purpose: directed bench for storage qualify and execute start
// Assumes: peer model shares the trigger line
// Notes: expressions use single match lines only
`timescale 1ns/10ps
`default_nettype none
module tb_trace_store_qualify_exec_start;
  logic       clk = 1'b0, rstn = 1'b0, analyzer_init = 1'b0, cfg_complex = 1'b0;
  logic       trigger_condition_set = 1'b0, global_expr_wr = 1'b0, term_expr_wr = 1'b0;
  logic       state_valid = 1'b0, exec_enable_wr = 1'b0, exec_enable_val = 1'b0;
  logic       exec_request = 1'b0, internal_trigger_line_a = 1'b0, internal_trigger_line_b = 1'b0;
  logic [2:0] expr_term = 3'h0, seq_term = 3'h0;
  logic [3:0] expr_value = 4'h0, state_match = 4'h0, hold_len = 4'h0;
  logic       shared_trig_out, shared_trig_oe, store_state, meas_start, exec_enabled;
  logic       exec_busy, peer_drive;
  wire logic  shared_trig_in;
  int         errors = 0, n_checks = 0, cycles = 0;
  trace_store_qualify_exec_start i_trace_store_qualify_exec_start (
    .clk (clk), .rstn (rstn), .analyzer_init (analyzer_init), .cfg_complex (cfg_complex),
    .trigger_condition_set (trigger_condition_set), .global_expr_wr (global_expr_wr),
    .term_expr_wr (term_expr_wr), .expr_term (expr_term), .expr_value (expr_value),
    .seq_term (seq_term), .state_valid (state_valid), .state_match (state_match),
    .exec_enable_wr (exec_enable_wr), .exec_enable_val (exec_enable_val),
    .exec_request (exec_request), .internal_trigger_line_a (internal_trigger_line_a),
    .internal_trigger_line_b (internal_trigger_line_b), .shared_trig_in (shared_trig_in),
    .shared_trig_out (shared_trig_out), .shared_trig_oe (shared_trig_oe),
    .store_state (store_state), .meas_start (meas_start), .exec_enabled (exec_enabled),
    .exec_busy (exec_busy)
  );
  trig_peer_model i_trig_peer_model (
    .clk (clk), .rstn (rstn), .shared_trig_oe (shared_trig_oe),
    .shared_trig_out (shared_trig_out), .hold_len (hold_len), .peer_drive (peer_drive)
  );
  assign shared_trig_in = (shared_trig_oe & shared_trig_out) | peer_drive;
  always #4 clk = ~clk;
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      test_done();
    end
  end
  task automatic chk(input string nm, input logic seen, input logic exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %b seen %b", nm, exp, seen);
    end
  endtask
  task automatic put(input logic g, input logic [2:0] t, input logic [3:0] v);
    @(posedge clk);
    global_expr_wr <= g;
    term_expr_wr <= !g;
    expr_term <= t;
    expr_value <= v;
    @(posedge clk);
    global_expr_wr <= 1'b0;
    term_expr_wr <= 1'b0;
  endtask
  task automatic st(input logic [2:0] t, input logic [3:0] m, input logic e);
    @(posedge clk);
    state_valid <= 1'b1;
    seq_term <= t;
    state_match <= m;
    @(posedge clk);
    state_valid <= 1'b0;
    @(posedge clk);
    #1 chk("store_state", store_state, e);
  endtask
  task automatic ex(input logic [3:0] h, input logic a, input logic b);
    int n;
    @(posedge clk);
    hold_len <= h;
    internal_trigger_line_a <= a;
    internal_trigger_line_b <= b;
    exec_request <= 1'b1;
    @(posedge clk);
    exec_request <= 1'b0;
    #1 chk("drive", shared_trig_oe & shared_trig_out & exec_busy, 1'b1);
    @(posedge clk);
    #1 chk("release", shared_trig_oe, 1'b0);
    chk("direct", meas_start, !(a | b));
    n = 2;
    while (exec_busy === 1'b1 && n < 40) begin
      @(posedge clk);
      #1 n++;
    end
    chk("wait_len", n == 3 + h, 1'b1);
    chk("late", meas_start, a | b);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("exec_enabled", exec_enabled, 1'b0);
    st(3'h0, 4'h0, 1'b1);
    $display("reset done");
    put(1'b1, 3'h0, 4'h2);
    put(1'b0, 3'h4, 4'h4);
    st(3'h4, 4'h2, 1'b1);
    st(3'h4, 4'h4, 1'b0);
    @(posedge clk);
    trigger_condition_set <= 1'b1;
    @(posedge clk);
    trigger_condition_set <= 1'b0;
    st(3'h7, 4'h1, 1'b0);
    st(3'h1, 4'h2, 1'b1);
    $display("easy done");
    @(posedge clk);
    cfg_complex <= 1'b1;
    @(posedge clk);
    st(3'h2, 4'h0, 1'b1);
    put(1'b1, 3'h0, 4'h1);
    put(1'b0, 3'h3, 4'h2);
    put(1'b0, 3'h7, 4'h8);
    st(3'h3, 4'h2, 1'b1);
    st(3'h5, 4'h2, 1'b0);
    st(3'h6, 4'h1, 1'b1);
    st(3'h7, 4'h8, 1'b1);
    st(3'h3, 4'h4, 1'b0);
    @(posedge clk);
    cfg_complex <= 1'b0;
    @(posedge clk);
    st(3'h3, 4'h4, 1'b1);
    $display("complex done");
    @(posedge clk);
    exec_request <= 1'b1;
    @(posedge clk);
    exec_request <= 1'b0;
    @(posedge clk);
    #1 chk("ignored", shared_trig_oe | exec_busy, 1'b0);
    @(posedge clk);
    exec_enable_wr <= 1'b1;
    exec_enable_val <= 1'b1;
    @(posedge clk);
    exec_enable_wr <= 1'b0;
    ex(4'h0, 1'b0, 1'b0);
    ex(4'h5, 1'b0, 1'b0);
    ex(4'h5, 1'b1, 1'b0);
    ex(4'h0, 1'b0, 1'b1);
    ex(4'h2, 1'b1, 1'b1);
    $display("execute done");
    put(1'b1, 3'h0, 4'h2);
    @(posedge clk);
    analyzer_init <= 1'b1;
    exec_enable_wr <= 1'b1;
    @(posedge clk);
    analyzer_init <= 1'b0;
    exec_enable_wr <= 1'b0;
    st(3'h1, 4'h0, 1'b1);
    chk("exec_enabled", exec_enabled, 1'b0);
    $display("init done");
    test_done();
  end
endmodule // tb_trace_store_qualify_exec_start
`default_nettype wire
